// file: design/bst_pkg.sv
package bst_pkg;

    // ------------------------------------------------------------
    // scan geometry
    // ------------------------------------------------------------
    localparam int IR_W      = 4;
    localparam int ID_W      = 32;
    localparam int PIN_IN_W  = 8;
    localparam int PIN_OUT_W = 8;
    localparam int BSC_W     = PIN_IN_W + PIN_OUT_W;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam logic [IR_W-1:0] INS_EXTEST  = 4'h0;
    localparam logic [IR_W-1:0] INS_SAMPLE  = 4'h1;
    localparam logic [IR_W-1:0] INS_IDCODE  = 4'h2;
    localparam logic [IR_W-1:0] INS_HIGHZ   = 4'h3;
    localparam logic [IR_W-1:0] INS_BYPASS  = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;

    // ------------------------------------------------------------
    // identification fields (values arbitrary)
    // ------------------------------------------------------------
    localparam logic [3:0]  ID_VERSION   = 4'h1;
    localparam logic [15:0] ID_PART      = 16'h5a5a;
    localparam logic [10:0] ID_VENDOR    = 11'h2a5;
    localparam logic        ID_PRESENT   = 1'b1;
    localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_VENDOR, ID_PRESENT};

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 8;
    localparam int TCK_PERIOD_NS     = 100;
    localparam int TCK_HALF_MIN_NS   = 40;
    localparam int TCK_HALF_MIN_CYC  =
        (TCK_HALF_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } bst_tap_pins_t;

    // test pins as seen during system reset: test reset released, clock low
    localparam bst_tap_pins_t TAP_SYNC_RST = '{tck: 1'b0, tms: 1'b0, tdi: 1'b0, trst_n: 1'b1};

    typedef enum logic [3:0] {
        TLR, RTI,
        SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } bst_tap_state_t;

endpackage

// file: design/bst_sync.sv
`timescale 1ns/10ps

// two-flop synchroniser bank; the first stage feeds only the second
module bst_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] async_i,
    input  wire logic [W-1:0] rst_val_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    // reset value is applied after the flops so no port reaches a reset branch
    assign sync_o = sys_rst_i ? rst_val_i : sync_q;

endmodule

// file: design/bst_tap.sv
`timescale 1ns/10ps

// Operation
// - the instruction register is four bits; only the defined codes are meant to be loaded.
// - code 0000 drives the boundary cells onto the outputs and selects the boundary chain.
// - code 1111 puts the one-bit bypass register between data in and data out.
// - code 0010 loads the 32-bit identification value and selects it.
// - code 0011 floats every output driver and selects the bypass register.
// - code 0001 selects the boundary chain and captures the input pins into it.
// - code 0001 also lets values be shifted into the boundary cells as a preload.
// - the test pins never sit in the boundary chain.
// - identification bits 31:28 hold the version.
// - identification bits 27:12 hold the part number.
// - identification bits 11:1 hold the vendor code.
// - identification bit 0 is always one.
// - test logic runs on the system clock only, stepping on edges of the synchronised test clock.
module bst_tap
    import bst_pkg::*;
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire bst_tap_pins_t        tap_i,
    input  wire logic [PIN_IN_W-1:0]  pin_in_i,
    input  wire logic [PIN_OUT_W-1:0] core_out_i,
    input  wire logic [PIN_OUT_W-1:0] core_oe_i,
    output logic      [PIN_IN_W-1:0]  core_in_o,
    output logic      [PIN_OUT_W-1:0] pin_out_o,
    output logic      [PIN_OUT_W-1:0] pin_oe_o,
    output logic                      tdo_o,
    output logic                      tdo_oe_o,
    output logic      [IR_W-1:0]      ir_o
);

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    bst_tap_pins_t        tap_s;
    logic [PIN_IN_W-1:0]  pin_s;
    logic                 tck_prev_q;
    logic                 tck_rise;
    logic                 tck_fall;
    logic                 tap_rst;

    bst_sync #(.W($bits(bst_tap_pins_t))) u_tap_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (tap_i),
        .rst_val_i (TAP_SYNC_RST),
        .sync_o    (tap_s)
    );

    bst_sync #(.W(PIN_IN_W)) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (pin_in_i),
        .rst_val_i ('0),
        .sync_o    (pin_s)
    );

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= tap_s.tck;
        end
    end

    assign tck_rise = tap_s.tck & ~tck_prev_q;
    assign tck_fall = ~tap_s.tck & tck_prev_q;
    assign tap_rst  = sys_rst_i | ~tap_s.trst_n;
    assign core_in_o = pin_s;

    // ------------------------------------------------------------
    // controller
    // ------------------------------------------------------------
    function automatic bst_tap_state_t tap_next(input bst_tap_state_t s, input logic tms);
        bst_tap_state_t n;
        n = s;
        case (s)
            TLR:    n = tms ? TLR    : RTI;
            RTI:    n = tms ? SEL_DR : RTI;
            SEL_DR: n = tms ? SEL_IR : CAP_DR;
            CAP_DR: n = tms ? EX1_DR : SHF_DR;
            SHF_DR: n = tms ? EX1_DR : SHF_DR;
            EX1_DR: n = tms ? UPD_DR : PAU_DR;
            PAU_DR: n = tms ? EX2_DR : PAU_DR;
            EX2_DR: n = tms ? UPD_DR : SHF_DR;
            UPD_DR: n = tms ? SEL_DR : RTI;
            SEL_IR: n = tms ? TLR    : CAP_IR;
            CAP_IR: n = tms ? EX1_IR : SHF_IR;
            SHF_IR: n = tms ? EX1_IR : SHF_IR;
            EX1_IR: n = tms ? UPD_IR : PAU_IR;
            PAU_IR: n = tms ? EX2_IR : PAU_IR;
            EX2_IR: n = tms ? UPD_IR : SHF_IR;
            UPD_IR: n = tms ? SEL_DR : RTI;
            default: n = TLR;
        endcase
        return n;
    endfunction

    bst_tap_state_t state_q;

    always_ff @(posedge sys_clk_i) begin
        if (tap_rst) begin
            state_q <= TLR;
        end else if (tck_rise) begin
            state_q <= tap_next(state_q, tap_s.tms);
        end
    end

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    logic [IR_W-1:0] ir_sr_q;
    logic [IR_W-1:0] ir_q;

    always_ff @(posedge sys_clk_i) begin
        if (tap_rst) begin
            ir_sr_q <= IR_CAPTURE;
        end else if (tck_rise && state_q == CAP_IR) begin
            ir_sr_q <= IR_CAPTURE;
        end else if (tck_rise && state_q == SHF_IR) begin
            ir_sr_q <= {tap_s.tdi, ir_sr_q[IR_W-1:1]};
        end
    end

    // update latches the shifted code; reserved codes fall back to bypass
    always_ff @(posedge sys_clk_i) begin
        if (tap_rst || state_q == TLR) begin
            ir_q <= INS_IDCODE;
        end else if (tck_fall && state_q == UPD_IR) begin
            ir_q <= ir_sr_q;
        end
    end

    assign ir_o = ir_q;

    logic sel_bsc;
    logic sel_id;

    // boundary chain on extest and sample
    assign sel_bsc = (ir_q == INS_EXTEST) || (ir_q == INS_SAMPLE);
    assign sel_id  = (ir_q == INS_IDCODE);

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    logic             byp_q;
    logic [ID_W-1:0]  id_sr_q;
    logic [BSC_W-1:0] bsc_sr_q;
    logic [BSC_W-1:0] bsc_upd_q;

    // bypass bit for bypass, highz and reserved codes
    always_ff @(posedge sys_clk_i) begin
        if (tap_rst) begin
            byp_q <= 1'b0;
        end else if (tck_rise && state_q == CAP_DR) begin
            byp_q <= 1'b0;
        end else if (tck_rise && state_q == SHF_DR) begin
            byp_q <= tap_s.tdi;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (tap_rst) begin
            id_sr_q <= ID_VALUE;
        end else if (tck_rise && state_q == CAP_DR && sel_id) begin
            id_sr_q <= ID_VALUE;
        end else if (tck_rise && state_q == SHF_DR && sel_id) begin
            id_sr_q <= {tap_s.tdi, id_sr_q[ID_W-1:1]};
        end
    end

    // sample captures data pins and core outputs; test pins have no cells
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            bsc_sr_q <= '0;
        end else if (tck_rise && state_q == CAP_DR && sel_bsc) begin
            bsc_sr_q <= {core_out_i, pin_s};
        end else if (tck_rise && state_q == SHF_DR && sel_bsc) begin
            bsc_sr_q <= {tap_s.tdi, bsc_sr_q[BSC_W-1:1]};
        end
    end

    // update stage keeps the pins steady while the chain shifts
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            bsc_upd_q <= '0;
        end else if (tck_fall && state_q == UPD_DR && sel_bsc) begin
            bsc_upd_q <= bsc_sr_q;
        end
    end

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    // extest forces cells, highz floats, otherwise core drives
    always_comb begin
        pin_out_o = core_out_i;
        pin_oe_o  = core_oe_i;
        if (ir_q == INS_EXTEST) begin
            pin_out_o = bsc_upd_q[BSC_W-1:PIN_IN_W];
            pin_oe_o  = '1;
        end else if (ir_q == INS_HIGHZ) begin
            pin_oe_o  = '0;
        end
    end

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    logic tdo_q;
    logic tdo_oe_q;
    logic tdo_src;

    always_comb begin
        if (state_q == SHF_IR) begin
            tdo_src = ir_sr_q[0];
        end else if (sel_bsc) begin
            tdo_src = bsc_sr_q[0];
        end else if (sel_id) begin
            tdo_src = id_sr_q[0];
        end else begin
            tdo_src = byp_q;
        end
    end

    // data out moves on the falling edge only
    always_ff @(posedge sys_clk_i) begin
        if (tap_rst) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q    <= tdo_src;
            tdo_oe_q <= (state_q == SHF_DR) || (state_q == SHF_IR);
        end
    end

    assign tdo_o    = tdo_q;
    assign tdo_oe_o = tdo_oe_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ir_reset_id: assert property (@(posedge sys_clk_i)
        tap_rst |=> ir_q == INS_IDCODE) else $error("reset did not select identification");

    a_tlr_normal_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        state_q == TLR |=> pin_oe_o == core_oe_i) else $error("reset state not functional");

    a_highz_all_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ir_q == INS_HIGHZ |-> pin_oe_o == '0) else $error("highz left a driver on");

    a_extest_drive_cells: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ir_q == INS_EXTEST |-> pin_oe_o == '1 && pin_out_o == bsc_upd_q[BSC_W-1:PIN_IN_W])
        else $error("extest not driving cells");

    a_bypass_capture_zero: assert property (@(posedge sys_clk_i) disable iff (tap_rst)
        tck_rise && state_q == CAP_DR |=> byp_q == 1'b0) else $error("bypass capture not 0");

    a_id_capture_value: assert property (@(posedge sys_clk_i) disable iff (tap_rst)
        tck_rise && state_q == CAP_DR && ir_q == INS_IDCODE |=>
        id_sr_q == ID_VALUE && id_sr_q[0] == 1'b1) else $error("id capture wrong");

    a_sample_pins_in: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        tck_rise && state_q == CAP_DR && ir_q == INS_SAMPLE |=>
        bsc_sr_q[PIN_IN_W-1:0] == $past(pin_s)) else $error("sample missed pins");

    a_preload_shift_in: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        tck_rise && state_q == SHF_DR && sel_bsc |=>
        bsc_sr_q[BSC_W-1] == $past(tap_s.tdi)) else $error("preload shift lost data");

    a_tdo_falling_only: assert property (@(posedge sys_clk_i) disable iff (tap_rst)
        $changed(tdo_q) |-> $past(tck_fall)) else $error("data out moved off falling edge");

    a_ir_update_load: assert property (@(posedge sys_clk_i) disable iff (tap_rst)
        tck_fall && state_q == UPD_IR |=> ir_q == $past(ir_sr_q)) else $error("ir update lost");

endmodule

// file: verification/bst_ctl_model.sv
`timescale 1ns/10ps

// test controller on the far side of the scan port; scans start and end in run-test-idle, test reset ends in test-logic-reset
module bst_ctl_model
    import bst_pkg::*;
(
    input  wire logic    sys_clk_i,
    input  wire logic    tdo_i,
    input  wire logic    tdo_oe_i,
    output bst_tap_pins_t tap_o
);
    // fixed rate
    // 160 ns test clock: ten system cycles per half period
    localparam int HALF = 10;

    // test clock stands low between bits
    initial tap_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};

    // ------------------------------------------------------------
    // one test clock period
    // ------------------------------------------------------------
    // tdo sampled before rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tap_o.tms <= tms;
        tap_o.tdi <= tdi;
        repeat (HALF - 1) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        tdo = tdo_oe_i ? tdo_i : 1'bx;
        @(posedge sys_clk_i);
        tap_o.tck <= 1'b1;
        repeat (HALF) @(posedge sys_clk_i);
        tap_o.tck <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // full scan of instruction or data path, lsb first
    // ------------------------------------------------------------
    // callers pass defined codes only
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b0, b);
        if (ir) begin
            step(1'b1, 1'b0, b);
        end
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask

    // test reset low for 80 ns, then the same again to recover
    task automatic test_reset();
        tap_o.trst_n <= 1'b0;
        repeat (HALF) @(posedge sys_clk_i);
        tap_o.trst_n <= 1'b1;
        repeat (HALF) @(posedge sys_clk_i);
    endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/10ps

module tb;
    import bst_pkg::*;

    logic                 sys_clk_i = 1'b0;
    logic                 sys_rst_i = 1'b1;
    bst_tap_pins_t        tap;
    logic [PIN_IN_W-1:0]  pin_in    = 8'h3c;
    logic [PIN_OUT_W-1:0] core_out  = 8'h5a;
    logic [PIN_OUT_W-1:0] core_oe   = 8'hc3;
    logic [PIN_IN_W-1:0]  core_in;
    logic [PIN_OUT_W-1:0] pin_out;
    logic [PIN_OUT_W-1:0] pin_oe;
    logic                 tdo;
    logic                 tdo_oe;
    logic [IR_W-1:0]      ir;
    logic [31:0]          d;
    logic                 b;
    // reserved codes must never be loaded, so the last entry checks leaving float mode
    logic [IR_W-1:0]      codes [3] = '{INS_BYPASS, INS_HIGHZ, INS_BYPASS};
    int                   bad_count  = 0;
    int                   n_compared = 0;

    always #4 sys_clk_i = ~sys_clk_i;

    bst_tap i_dut (
        .sys_clk_i  (sys_clk_i),
        .sys_rst_i  (sys_rst_i),
        .tap_i      (tap),
        .pin_in_i   (pin_in),
        .core_out_i (core_out),
        .core_oe_i  (core_oe),
        .core_in_o  (core_in),
        .pin_out_o  (pin_out),
        .pin_oe_o   (pin_oe),
        .tdo_o      (tdo),
        .tdo_oe_o   (tdo_oe),
        .ir_o       (ir)
    );

    bst_ctl_model i_ctl (
        .sys_clk_i (sys_clk_i),
        .tdo_i     (tdo),
        .tdo_oe_i  (tdo_oe),
        .tap_o     (tap)
    );

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog: the whole run is far shorter than this
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        bad_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        check(ir, INS_IDCODE);
        check(pin_oe, core_oe);
        check(pin_out, core_out);
        check(core_in, pin_in);
        i_ctl.step(1'b0, 1'b0, b);
        check(tdo_oe, 1'b0);
        $display("test reset_state done");

        i_ctl.scan(1'b0, 32, 32'h0, d);
        check(d, ID_VALUE);
        check(d[31:28], ID_VERSION);
        check(d[27:12], ID_PART);
        check(d[11:1], ID_VENDOR);
        check(d[0], 1'b1);
        $display("test idcode done");

        // bypass and float both give a one-bit path
        for (int k = 0; k < 3; k++) begin
            i_ctl.scan(1'b1, 4, {28'h0, codes[k]}, d);
            check(d[3:0], IR_CAPTURE);
            check(ir, codes[k]);
            i_ctl.scan(1'b0, 8, 32'hb5, d);
            check(d[7:0], 8'h6a);
            check(pin_oe, (codes[k] == INS_HIGHZ) ? 8'h00 : core_oe);
        end
        $display("test bypass_highz done");

        // 24 bits through a 16-cell chain: the tail proves its length
        i_ctl.scan(1'b1, 4, {28'h0, INS_SAMPLE}, d);
        check(ir, INS_SAMPLE);
        i_ctl.scan(1'b0, 24, 32'h9e1742, d);
        check(d[23:0], {8'h42, core_out, pin_in});
        check(d[23:16], 8'h42);
        $display("test sample done");

        i_ctl.scan(1'b1, 4, {28'h0, INS_EXTEST}, d);
        check(pin_out, 8'h9e);
        check(pin_oe, 8'hff);
        $display("test extest done");

        for (int k = 0; k < 5; k++) begin
            i_ctl.step(1'b1, 1'b0, b);
        end
        i_ctl.step(1'b0, 1'b0, b);
        check(ir, INS_IDCODE);
        check(pin_out, core_out);
        $display("test tms_reset done");

        // bypass must really be loaded, or the reset check below proves nothing
        i_ctl.scan(1'b1, 4, {28'h0, INS_BYPASS}, d);
        check(ir, INS_BYPASS);
        i_ctl.test_reset();
        check(ir, INS_IDCODE);
        i_ctl.step(1'b0, 1'b0, b);
        $display("test trst done");
        wrap_up();
    end
endmodule
